// File: verilog/frspe_map.svh
// constants for the flash reset sequencer and serial program entry
`ifndef FRSPE_MAP_SVH
`define FRSPE_MAP_SVH

// clock period of mclk
`define FRSPE_CLK_NS 50
// least valid low width of the hardware reset pin
`define FRSPE_RST_MIN_NS 500
`define FRSPE_RST_MIN_CYC \
	((`FRSPE_RST_MIN_NS + `FRSPE_CLK_NS - 1) / `FRSPE_CLK_NS)
// flash initialisation time before data is readable
`define FRSPE_INIT_US 20
`define FRSPE_INIT_CYC ((`FRSPE_INIT_US * 1000) / `FRSPE_CLK_NS)

// mode strap levels high-to-low for serial programming
`define FRSPE_STRAP_SERIAL 3'h3
`define FRSPE_PIN22_SERIAL 1'h1
`define FRSPE_PIN23_SERIAL 1'h0
`define FRSPE_PIN10_SERIAL 1'h1

// cpu clock divider and serial clock ratio in serial mode
`define FRSPE_CPU_DIV 4
`define FRSPE_SCK_RATIO 8
`define FRSPE_SCK_HALF_MIN (`FRSPE_SCK_RATIO / 2)

// value shifted out before the first byte is supplied
`define FRSPE_TX_IDLE 8'hFF

`endif

// File: verilog/frspe_pkg.sv
// types shared by the flash reset sequencer and serial program entry
package frspe_pkg;
	// flash sequencer states
	typedef enum logic [1:0] {
		FRSPE_ST_INIT = 2'b00,
		FRSPE_ST_READY = 2'b01,
		FRSPE_ST_BUSY = 2'b10
	} frspe_state_t;

	// kind of automatic algorithm
	typedef enum logic {
		FRSPE_OP_WRITE = 1'b0,
		FRSPE_OP_ERASE = 1'b1
	} frspe_op_t;
endpackage

// File: verilog/frspe_buf.sv
// shifting buffer between the serial receiver and the user side
`timescale 1ns/1ps
module frspe_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic mclk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic in_valid, // word offered
	output logic in_ready, // room for a word
	input wire logic [WIDTH-1:0] in_data, // offered word
	output logic out_valid, // head word valid
	input wire logic out_ready, // consumer takes head
	output logic [WIDTH-1:0] out_data // head word
);
	import frspe_pkg::*;

	if (DEPTH < 2) begin : g_chk
		$error("frspe_buf needs at least two entries");
	end

	logic [DEPTH-1:0] vld;
	logic [WIDTH-1:0] mem [DEPTH];
	logic [DEPTH-1:0] next_vld;
	logic [WIDTH-1:0] next_mem [DEPTH];
	logic pop;
	logic push;
	logic placed;

	// head always sits in entry zero so the output is a flop
	assign pop = vld[0] & out_ready;
	assign push = in_valid & ~vld[DEPTH-1];
	assign in_ready = ~vld[DEPTH-1];
	assign out_valid = vld[0];
	assign out_data = mem[0];

	// shift down on pop, then place a pushed word in the first hole
	always_comb begin
		placed = 1'b0;
		// last entry handled apart so no index runs past the array
		for (int i = 0; i < DEPTH - 1; i++) begin
			next_vld[i] = pop ? vld[i+1] : vld[i];
			next_mem[i] = pop ? mem[i+1] : mem[i];
		end
		next_vld[DEPTH-1] = pop ? 1'b0 : vld[DEPTH-1];
		next_mem[DEPTH-1] = mem[DEPTH-1];
		for (int i = 0; i < DEPTH; i++) begin
			if (push && !placed && !next_vld[i]) begin
				next_vld[i] = 1'b1;
				next_mem[i] = in_data;
				placed = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			vld <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
		end else begin
			vld <= next_vld;
			mem <= next_mem;
		end
	end

	// a stalled consumer keeps the head word unchanged
	AST_HOLD_HEAD: assert property (@(posedge mclk) disable iff (!rst_n)
		out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("buffer head changed while stalled");
endmodule

// File: verilog/frspe_top.sv
// flash reset sequencer with serial programming mode entry
`timescale 1ns/1ps
`include "frspe_map.svh"
module frspe_top #(
	parameter int DATA_W = 8,
	parameter int BUF_DEPTH = 2
) (
	input wire logic mclk, // oscillator clock, 20 MHz
	input wire logic rst_n, // power-on reset, active low
	input wire logic ext_reset_n, // hardware reset pin, active low
	input wire logic sw_reset, // software or watchdog reset pulse
	input wire logic mode_strap_high, // mode strap, top bit
	input wire logic mode_strap_mid, // mode strap, middle bit
	input wire logic mode_strap_low, // mode strap, low bit
	input wire logic port_pin_twenty_two, // strap port pin 22
	input wire logic port_pin_twenty_three, // strap port pin 23
	input wire logic port_pin_ten, // strap port pin 10
	input wire logic cmd_valid, // start request for the algorithm
	input wire frspe_pkg::frspe_op_t cmd_op, // write or erase
	input wire logic algo_finish, // array reports algorithm done
	input wire logic rd_req, // cpu read of the flash array
	output logic rd_ack, // read granted
	output logic rd_refused, // read refused, flash not readable
	output logic algo_start, // pulse, algorithm launched
	output logic cmd_ignored, // pulse, command dropped while busy
	output logic flash_busy, // automatic algorithm active
	output logic flash_ready, // flash in read state
	output logic data_suspect, // write was cut by reset
	output logic sector_suspect, // erase was cut by reset
	output logic serial_mode, // serial programming mode latched
	output logic cpu_tick, // cpu clock enable pulse
	input wire logic prog_serial_clock_in, // serial clock from programmer
	input wire logic prog_serial_data_in, // serial data in
	output logic prog_serial_data_out, // serial data out
	output logic sck_too_fast, // serial clock over ratio seen
	output logic rx_overrun, // byte lost, buffer full
	output logic rx_valid, // received byte ready
	input wire logic rx_ready, // user takes the byte
	output logic [DATA_W-1:0] rx_data, // received byte
	input wire logic [DATA_W-1:0] tx_data, // next byte to send
	output logic tx_taken // pulse, tx_data loaded
);
	import frspe_pkg::*;

	if (DATA_W != 8) begin : g_chk_w
		$error("frspe_top serial port is eight bits wide");
	end
	if (BUF_DEPTH < 2) begin : g_chk_d
		$error("frspe_top needs a buffer of two or more");
	end

	localparam int RST_CYC = `FRSPE_RST_MIN_CYC;
	localparam int INIT_CYC = `FRSPE_INIT_CYC;
	localparam logic [3:0] RST_LAST = 4'(RST_CYC - 1);
	localparam logic [8:0] INIT_LAST = 9'(INIT_CYC - 1);
	localparam logic [2:0] HALF_LAST = 3'(`FRSPE_SCK_HALF_MIN - 1);
	localparam logic [1:0] DIV_LAST = 2'(`FRSPE_CPU_DIV - 1);

	// strap decoding, used at capture and by the check below
	function automatic logic strap_is_serial(input logic [2:0] m,
		input logic p22, input logic p23, input logic p10);
		strap_is_serial = (m == `FRSPE_STRAP_SERIAL) &&
			(p22 == `FRSPE_PIN22_SERIAL) &&
			(p23 == `FRSPE_PIN23_SERIAL) && (p10 == `FRSPE_PIN10_SERIAL);
	endfunction

	logic [2:0] strap;
	assign strap = {mode_strap_high, mode_strap_mid, mode_strap_low};

	// reset pin filter: a low shorter than the minimum does nothing
	logic [3:0] low_cnt, next_low_cnt;
	logic rst_hit;
	assign rst_hit = !ext_reset_n && (low_cnt == RST_LAST);
	always_comb begin
		next_low_cnt = low_cnt;
		if (ext_reset_n) begin
			next_low_cnt = '0;
		end else if (low_cnt != RST_LAST + 4'h1) begin
			next_low_cnt = low_cnt + 4'h1; // saturate past the minimum
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt <= '0;
		end else begin
			low_cnt <= next_low_cnt;
		end
	end

	// flash sequencer
	frspe_state_t state, next_state;
	frspe_op_t op, next_op;
	logic [8:0] init_cnt, next_init_cnt;
	logic next_data_suspect, next_sector_suspect;
	logic reset_held;
	assign reset_held = !ext_reset_n && (low_cnt > RST_LAST);
	always_comb begin
		next_state = state;
		next_op = op;
		next_init_cnt = init_cnt;
		next_data_suspect = data_suspect;
		next_sector_suspect = sector_suspect;
		// sw_reset is deliberately not looked at here
		unique case (state)
			FRSPE_ST_INIT: begin
				if (reset_held) begin
					next_init_cnt = '0; // restart timing until pin rises
				end else if (init_cnt == INIT_LAST) begin
					next_state = FRSPE_ST_READY;
				end else begin
					next_init_cnt = init_cnt + 9'h001;
				end
			end
			FRSPE_ST_READY: begin
				if (cmd_valid) begin
					next_state = FRSPE_ST_BUSY;
					next_op = cmd_op;
				end
			end
			FRSPE_ST_BUSY: begin
				if (algo_finish) begin
					next_state = FRSPE_ST_READY;
				end
			end
			default: next_state = FRSPE_ST_INIT;
		endcase
		// a valid reset pin wins everywhere and reinitialises the flash
		if (rst_hit) begin
			next_state = FRSPE_ST_INIT;
			next_init_cnt = '0;
			if (state == FRSPE_ST_BUSY && !algo_finish) begin
				if (op == FRSPE_OP_WRITE) begin
					next_data_suspect = 1'b1;
				end else begin
					next_sector_suspect = 1'b1;
				end
			end
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= FRSPE_ST_INIT;
			op <= FRSPE_OP_WRITE;
			init_cnt <= '0;
			data_suspect <= 1'b0;
			sector_suspect <= 1'b0;
		end else begin
			state <= next_state;
			op <= next_op;
			init_cnt <= next_init_cnt;
			data_suspect <= next_data_suspect;
			sector_suspect <= next_sector_suspect;
		end
	end

	// registered status and per-request answers
	logic next_rd_ack, next_rd_refused, next_algo_start, next_cmd_ignored;
	always_comb begin
		next_rd_ack = rd_req && state == FRSPE_ST_READY;
		next_rd_refused = rd_req && state != FRSPE_ST_READY;
		next_algo_start = cmd_valid && state == FRSPE_ST_READY && !rst_hit;
		next_cmd_ignored = cmd_valid && state == FRSPE_ST_BUSY;
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rd_ack <= 1'b0;
			rd_refused <= 1'b0;
			algo_start <= 1'b0;
			cmd_ignored <= 1'b0;
			flash_busy <= 1'b0;
			flash_ready <= 1'b0;
		end else begin
			rd_ack <= next_rd_ack;
			rd_refused <= next_rd_refused;
			algo_start <= next_algo_start;
			cmd_ignored <= next_cmd_ignored;
			flash_busy <= next_state == FRSPE_ST_BUSY;
			flash_ready <= next_state == FRSPE_ST_READY;
		end
	end

	// strap capture after reset release; async reset may only load constants
	logic strap_done, next_strap_done, next_serial_mode;
	logic [1:0] div_cnt, next_div_cnt;
	logic next_cpu_tick;
	always_comb begin
		next_strap_done = strap_done & ~rst_hit;
		next_serial_mode = serial_mode;
		if (!strap_done) begin
			next_serial_mode = strap_is_serial(strap, port_pin_twenty_two,
				port_pin_twenty_three, port_pin_ten);
			next_strap_done = 1'b1;
		end
		next_div_cnt = (div_cnt == DIV_LAST) ? 2'h0 : div_cnt + 2'h1;
		next_cpu_tick = serial_mode ? (div_cnt == DIV_LAST) : 1'b1;
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			strap_done <= 1'b0;
			serial_mode <= 1'b0;
			div_cnt <= '0;
			cpu_tick <= 1'b0;
		end else begin
			strap_done <= next_strap_done;
			serial_mode <= next_serial_mode;
			div_cnt <= next_div_cnt;
			cpu_tick <= next_cpu_tick;
		end
	end

	// serial port: sample on rising sck, shift out on falling sck
	logic sck_q;
	logic [2:0] bit_cnt, next_bit_cnt;
	logic [2:0] half_cnt, next_half_cnt;
	logic [7:0] rx_sh, next_rx_sh, tx_sh, next_tx_sh;
	logic next_so, next_fast, next_overrun, next_tx_taken;
	logic push, push_ready, next_push;
	logic sck_rise, sck_fall;
	assign sck_rise = serial_mode && prog_serial_clock_in && !sck_q;
	assign sck_fall = serial_mode && !prog_serial_clock_in && sck_q;
	always_comb begin
		next_bit_cnt = bit_cnt;
		next_rx_sh = rx_sh;
		next_tx_sh = tx_sh;
		next_so = prog_serial_data_out;
		next_fast = sck_too_fast;
		next_overrun = rx_overrun;
		next_tx_taken = 1'b0;
		next_push = 1'b0;
		next_half_cnt = (half_cnt == HALF_LAST) ? half_cnt : half_cnt + 3'h1;
		if (sck_rise || sck_fall) begin
			next_half_cnt = '0;
			// an edge before the least half period means over one eighth
			if (half_cnt != HALF_LAST) begin
				next_fast = 1'b1;
			end
		end
		if (sck_rise) begin
			next_rx_sh = {rx_sh[6:0], prog_serial_data_in};
			next_bit_cnt = bit_cnt + 3'h1;
			if (bit_cnt == 3'h7) begin
				next_push = 1'b1;
				next_tx_sh = tx_data;
				next_so = tx_data[7];
				next_tx_taken = 1'b1;
				// programmer cannot be stalled, so a full buffer drops it
				if (!push_ready) begin
					next_overrun = 1'b1;
				end
			end
		end else if (sck_fall && bit_cnt != 3'h0) begin
			next_tx_sh = {tx_sh[6:0], 1'b0};
			next_so = tx_sh[6];
		end
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sck_q <= 1'b0;
			bit_cnt <= '0;
			half_cnt <= HALF_LAST;
			rx_sh <= '0;
			tx_sh <= `FRSPE_TX_IDLE;
			prog_serial_data_out <= 1'b1;
			sck_too_fast <= 1'b0;
			rx_overrun <= 1'b0;
			tx_taken <= 1'b0;
			push <= 1'b0;
		end else begin
			sck_q <= prog_serial_clock_in;
			bit_cnt <= next_bit_cnt;
			half_cnt <= next_half_cnt;
			rx_sh <= next_rx_sh;
			tx_sh <= next_tx_sh;
			prog_serial_data_out <= next_so;
			sck_too_fast <= next_fast;
			rx_overrun <= next_overrun;
			tx_taken <= next_tx_taken;
			push <= next_push;
		end
	end

	// two-entry buffer absorbs a user stall of up to one byte time
	frspe_buf #(.WIDTH(DATA_W), .DEPTH(BUF_DEPTH)) u_rx_buf (
		.mclk(mclk),
		.rst_n(rst_n),
		.in_valid(push),
		.in_ready(push_ready),
		.in_data(rx_sh),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_data)
	);

	AST_SHORT_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
		state != FRSPE_ST_INIT && !ext_reset_n && low_cnt < RST_LAST |=>
		state != FRSPE_ST_INIT)
		else $error("short reset pulse reinitialised flash");
	AST_INIT_TIME: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(flash_ready) && $past(state) == FRSPE_ST_INIT |->
		$past(init_cnt) == INIT_LAST)
		else $error("flash ready before init time");
	AST_CUT_ERASE: assert property (@(posedge mclk) disable iff (!rst_n)
		state == FRSPE_ST_BUSY && op == FRSPE_OP_ERASE && rst_hit &&
		!algo_finish |=> sector_suspect && state == FRSPE_ST_INIT)
		else $error("erase cut without sector mark");
	AST_SOFT_KEEP: assert property (@(posedge mclk) disable iff (!rst_n)
		state == FRSPE_ST_BUSY && sw_reset && !algo_finish && !rst_hit |=>
		flash_busy)
		else $error("soft reset disturbed the algorithm");
	AST_READ_GATE: assert property (@(posedge mclk) disable iff (!rst_n)
		rd_req && flash_busy |=> rd_refused && !rd_ack)
		else $error("read granted while busy");
	AST_STRAP: assert property (@(posedge mclk) disable iff (!rst_n)
		!strap_done |=> serial_mode == strap_is_serial($past(strap),
		$past(port_pin_twenty_two), $past(port_pin_twenty_three),
		$past(port_pin_ten)))
		else $error("serial mode not taken from straps");
	AST_DIV4: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(serial_mode) && serial_mode && cpu_tick ##1 serial_mode[*3]
		|-> (!$past(cpu_tick, 2) && !$past(cpu_tick) && !cpu_tick) ##1
		cpu_tick)
		else $error("cpu tick not one in four");
	AST_FAST: assert property (@(posedge mclk) disable iff (!rst_n)
		(sck_rise || sck_fall) && half_cnt < HALF_LAST |=> sck_too_fast)
		else $error("fast serial clock not flagged");
	AST_BYTE: assert property (@(posedge mclk) disable iff (!rst_n)
		sck_rise && bit_cnt == 3'h7 |=> push && tx_taken && bit_cnt == 3'h0)
		else $error("eighth bit did not complete a byte");
	AST_IGNORE: assert property (@(posedge mclk) disable iff (!rst_n)
		cmd_valid && flash_busy && state == FRSPE_ST_BUSY |=>
		cmd_ignored && !algo_start)
		else $error("command accepted while busy");
	AST_BUSY: assert property (@(posedge mclk) disable iff (!rst_n)
		state == FRSPE_ST_READY && cmd_valid && !rst_hit |=>
		flash_busy && algo_start)
		else $error("busy not raised on start");
endmodule

// File: bench/frspe_prog.sv
// programmer model on the far side of the clocked serial port
`timescale 1ns/1ps
module frspe_prog (
	input wire logic mclk, // device oscillator clock
	output logic sck, // serial clock into the device
	output logic si, // serial data into the device
	input wire logic so // serial data from the device
);
	// clock rests low outside frames; data shows no stale level there
	initial begin
		sck = 1'b0;
		si = 1'b1;
	end

	// move only just after an oscillator edge
	task automatic hold(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// one byte msb first; half of four cycles or more keeps sck at
	// or below an eighth of the oscillator, two breaks that on purpose
	task automatic xfer(input logic [7:0] b, input int half,
		output logic [7:0] got);
		got = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			sck = 1'b0;
			si = b[i];
			hold(half);
			got = {got[6:0], so};
			sck = 1'b1;
			hold(half);
		end
	endtask

	// close the frame: clock back low, data line flipped; one more
	// edge passes so the next frame never rewrites a line in this step
	task automatic idle(input int half);
		hold(half);
		sck = 1'b0;
		si = ~si;
		hold(1);
	endtask
endmodule

// File: bench/frspe_top_tb.sv
// self-checking testbench for the flash reset sequencer and serial entry
`timescale 1ns/1ps
module frspe_top_tb;
	import frspe_pkg::*;
	localparam logic [5:0] TBL [6] = '{6'h05, 6'h19, 6'h1F, 6'h1C,
		6'h3D, 6'h1D};
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic ext_reset_n = 1'b1;
	logic sw_reset = 1'b0;
	logic [5:0] strap = 6'h00; // {high, mid, low, pin22, pin23, pin10}
	logic cmd_valid = 1'b0;
	frspe_op_t cmd_op = FRSPE_OP_WRITE;
	logic algo_finish = 1'b0;
	logic rd_req = 1'b0;
	logic rx_ready = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic rd_ack, rd_refused, algo_start, cmd_ignored, flash_busy;
	logic flash_ready, data_suspect, sector_suspect, serial_mode;
	logic cpu_tick, sck, si, so, sck_too_fast, rx_overrun, rx_valid;
	logic tx_taken;
	logic [7:0] rx_data;
	logic [7:0] got;
	int fails = 0;
	int checked = 0;
	int n_start = 0;
	int n_ign = 0;
	int n_ack = 0;
	int n_ref = 0;
	int n_taken = 0;
	int n_tick = 0;

	// 20 MHz oscillator, well above the 3 MHz floor
	always #25 mclk = ~mclk;

	frspe_top u_dut (.mclk(mclk), .rst_n(rst_n),
		.ext_reset_n(ext_reset_n), .sw_reset(sw_reset),
		.mode_strap_high(strap[5]), .mode_strap_mid(strap[4]),
		.mode_strap_low(strap[3]), .port_pin_twenty_two(strap[2]),
		.port_pin_twenty_three(strap[1]), .port_pin_ten(strap[0]),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .algo_finish(algo_finish),
		.rd_req(rd_req), .rd_ack(rd_ack), .rd_refused(rd_refused),
		.algo_start(algo_start), .cmd_ignored(cmd_ignored),
		.flash_busy(flash_busy), .flash_ready(flash_ready),
		.data_suspect(data_suspect), .sector_suspect(sector_suspect),
		.serial_mode(serial_mode), .cpu_tick(cpu_tick),
		.prog_serial_clock_in(sck), .prog_serial_data_in(si),
		.prog_serial_data_out(so), .sck_too_fast(sck_too_fast),
		.rx_overrun(rx_overrun), .rx_valid(rx_valid), .rx_ready(rx_ready),
		.rx_data(rx_data), .tx_data(tx_data), .tx_taken(tx_taken));

	frspe_prog u_prog (.mclk(mclk), .sck(sck), .si(si), .so(so));

	// pulse outputs last one cycle, so count them at every edge
	always @(posedge mclk) begin
		if (algo_start === 1'b1) n_start++;
		if (cmd_ignored === 1'b1) n_ign++;
		if (rd_ack === 1'b1) n_ack++;
		if (rd_refused === 1'b1) n_ref++;
		if (tx_taken === 1'b1) n_taken++;
		if (cpu_tick === 1'b1) n_tick++;
	end

	task automatic print_verdict();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check_bit(input string name, input logic exp,
		input logic seen);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %b seen %b", name, exp, seen);
		end
	endtask

	task automatic check_byte(input string name, input logic [7:0] exp,
		input logic [7:0] seen);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic check_cnt(input string name, input int exp,
		input int seen);
		checked++;
		if (seen != exp) begin
			fails++;
			$display("mismatch %s expected %0d seen %0d", name, exp, seen);
		end
	endtask

	// inputs move one nanosecond after the rising edge
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		step(1);
		s = 1'b0;
	endtask

	// bounded wait for the read state; running out ends the run
	task automatic wait_ready(output int n);
		n = 0;
		while (flash_ready !== 1'b1 && n < 2000) begin
			step(1);
			n++;
		end
		check_bit("flash_ready", 1'b1, flash_ready);
		if (n >= 2000) print_verdict();
	endtask

	task automatic pin_reset(input int n);
		ext_reset_n = 1'b0;
		step(n);
		ext_reset_n = 1'b1;
		step(2);
	endtask

	// take one received byte; rx_ready held one edge, then low one edge
	task automatic pop(input logic [7:0] exp);
		int k;
		k = 0;
		while (rx_valid !== 1'b1 && k < 40) begin
			step(1);
			k++;
		end
		check_bit("rx_valid", 1'b1, rx_valid);
		if (k >= 40) print_verdict();
		check_byte("rx_data", exp, rx_data);
		rx_ready = 1'b1;
		step(1);
		rx_ready = 1'b0;
		step(1);
	endtask

	initial begin
		int n;
		int t0;
		step(20);
		check_bit("so_reset", 1'b1, so);
		check_bit("ready_reset", 1'b0, flash_ready);
		rst_n = 1'b1;
		wait_ready(n);
		check_bit("init_len", 1'b1, n >= 396 && n <= 406);
		pulse(rd_req);
		step(1);
		check_cnt("rd_ack", 1, n_ack);
		// write runs: reads refused, commands dropped, sw reset ignored
		pulse(cmd_valid);
		step(1);
		check_cnt("algo_start", 1, n_start);
		check_bit("busy", 1'b1, flash_busy);
		check_bit("ready", 1'b0, flash_ready);
		pulse(rd_req);
		step(1);
		check_cnt("rd_refused", 1, n_ref);
		pulse(cmd_valid);
		step(1);
		check_cnt("cmd_ignored", 1, n_ign);
		check_cnt("algo_start", 1, n_start);
		pulse(sw_reset);
		step(3);
		check_bit("busy_sw", 1'b1, flash_busy);
		pulse(algo_finish);
		step(1);
		check_bit("busy_end", 1'b0, flash_busy);
		check_bit("ready_end", 1'b1, flash_ready);
		check_bit("data_suspect", 1'b0, data_suspect);
		// nine low samples fall short of 500 ns
		pin_reset(9);
		check_bit("ready_short", 1'b1, flash_ready);
		pulse(cmd_valid);
		step(1);
		pin_reset(10);
		check_bit("busy_pin", 1'b0, flash_busy);
		check_bit("data_suspect", 1'b1, data_suspect);
		check_bit("sector_suspect", 1'b0, sector_suspect);
		pulse(rd_req);
		step(1);
		check_cnt("rd_refused", 2, n_ref);
		wait_ready(n);
		check_bit("reinit_len", 1'b1, n >= 392 && n <= 404);
		cmd_op = FRSPE_OP_ERASE;
		// erase runs with no soft reset and no vector fetch from flash
		pulse(cmd_valid);
		step(1);
		pin_reset(12);
		check_bit("sector_suspect", 1'b1, sector_suspect);
		wait_ready(n);
		// strap combinations; board straps low, programmer sets 11
		for (int i = 0; i < 6; i++) begin
			strap = TBL[i];
			pin_reset(10);
			step(1);
			check_bit("serial_mode", TBL[i] == 6'h1D, serial_mode);
			t0 = n_tick;
			step(40);
			check_cnt("cpu_tick", TBL[i] == 6'h1D ? 10 : 40,
				n_tick - t0);
		end
		// first byte: output idles high, then next byte loads msb
		tx_data = 8'h3C;
		u_prog.xfer(8'hA5, 4, got);
		check_byte("so_idle", 8'hFF, got);
		step(3);
		check_bit("so_msb", 1'b0, so);
		check_cnt("tx_taken", 1, n_taken);
		u_prog.idle(4);
		pop(8'hA5);
		// receiver stalls: third byte finds the buffer full
		u_prog.xfer(8'h5A, 4, got);
		check_byte("so_byte", 8'h3C, got);
		u_prog.idle(4);
		u_prog.xfer(8'hC3, 4, got);
		u_prog.idle(4);
		u_prog.xfer(8'h0F, 4, got);
		u_prog.idle(4);
		step(4);
		check_bit("rx_overrun", 1'b1, rx_overrun);
		pop(8'h5A);
		pop(8'hC3);
		step(3);
		check_bit("rx_empty", 1'b0, rx_valid);
		check_bit("sck_fast", 1'b0, sck_too_fast);
		u_prog.xfer(8'h81, 2, got);
		u_prog.idle(2);
		step(2);
		check_bit("sck_fast", 1'b1, sck_too_fast);
		pop(8'h81);
		print_verdict();
	end
endmodule
